// ===== rtl/srg_pkg.sv
// Package for the protected range guard: register offset, field layout, reset values.
// Assumes a message-port style register access with word addresses and 32-bit data.
package srg_pkg;
   // Register index on the message port
   localparam logic [7:0]  SRG_CTRL_OFFSET   = 8'h04;
   // Field positions
   localparam int          SRG_TOP_MSB       = 31;
   localparam int          SRG_TOP_LSB       = 20;
   localparam int          SRG_BOT_MSB       = 15;
   localparam int          SRG_BOT_LSB       = 4;
   localparam int          SRG_OA_WR_BIT     = 18;
   localparam int          SRG_OA_RD_BIT     = 17;
   localparam int          SRG_OM_WR_BIT     = 2;
   localparam int          SRG_OM_RD_BIT     = 1;
   localparam int          SRG_FREEZE_BIT    = 0;
   // Reset values
   localparam logic [11:0] SRG_TOP_RST       = 12'h000;
   localparam logic [11:0] SRG_BOT_RST       = 12'h000;
   localparam logic        SRG_OPEN_RST      = 1'h1;
   localparam logic        SRG_FREEZE_RST    = 1'h0;
   // Writable bits; spare bits 19, 16 and 3 are absent
   localparam logic [31:0] SRG_WR_MASK       = 32'hFFF6FFF7;
   // Cycles from access request to decision
   localparam int          SRG_DECIDE_CYCLES = 1;
endpackage

// ===== rtl/srg_cfg_if.sv
// Interface carrying the configuration fields from the register to the checker.
// Assumes one clock domain; fields are registered values.
interface srg_cfg_if;
   logic [11:0] top_bound;
   logic [11:0] bottom_bound;
   logic        outside_mode_write_open;
   logic        outside_mode_read_open;
   logic        other_agent_write_open;
   logic        other_agent_read_open;
   modport src (output top_bound, bottom_bound, outside_mode_write_open, outside_mode_read_open,
                other_agent_write_open, other_agent_read_open);
   modport dst (input top_bound, bottom_bound, outside_mode_write_open, outside_mode_read_open,
                other_agent_write_open, other_agent_read_open);
endinterface

// ===== rtl/srg_access_check.sv
// Access checker: decides whether one memory access may proceed.
// Assumes request fields are stable while acc_valid is high; answer a cycle later.
module srg_access_check
   import srg_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Configuration
   srg_cfg_if.dst           cfg,
   // Access request
   input  wire logic        acc_valid,
   input  wire logic [31:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic        acc_host,
   input  wire logic        acc_smm,
   // Decision
   output logic             dec_valid_r,
   output logic             dec_allow_r,
   output logic             dec_in_range_r
);
   // Inclusive compare on 1MB granules; low 20 bits never matter
   function automatic logic in_range(input logic [31:0] a, input logic [11:0] lo, input logic [11:0] hi);
      return (a[31:20] >= lo) && (a[31:20] <= hi);
   endfunction

   logic hit;
   logic open_ok;
   logic allow_nxt;

   // Open bits chosen by requester class and direction
   always_comb begin
      hit = in_range(acc_addr, cfg.bottom_bound, cfg.top_bound);
      if (acc_host) begin
         open_ok = acc_write ? cfg.outside_mode_write_open : cfg.outside_mode_read_open;
      end else begin
         open_ok = acc_write ? cfg.other_agent_write_open : cfg.other_agent_read_open;
      end
      allow_nxt = !hit || (acc_host && acc_smm) || open_ok;
   end

   // Registered decision
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_valid_r    <= 1'b0;
         dec_allow_r    <= 1'b0;
         dec_in_range_r <= 1'b0;
      end else begin
         dec_valid_r    <= acc_valid;
         dec_allow_r    <= acc_valid && allow_nxt;
         dec_in_range_r <= acc_valid && hit;
      end
   end

   a_smm_host_allowed: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid && acc_host && acc_smm |=> dec_allow_r)
      else $error("SMM host access was blocked");
   a_other_wr_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid && !acc_host && acc_write && hit && !cfg.other_agent_write_open |=> !dec_allow_r)
      else $error("Other-agent write not blocked");
   a_other_rd_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid && !acc_host && !acc_write && hit && !cfg.other_agent_read_open |=> !dec_allow_r)
      else $error("Other-agent read not blocked");
   a_host_wr_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid && acc_host && !acc_smm && acc_write && hit && !cfg.outside_mode_write_open
      |=> !dec_allow_r)
      else $error("Non-SMM host write not blocked");
   a_host_rd_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid && acc_host && !acc_smm && !acc_write && hit && !cfg.outside_mode_read_open
      |=> !dec_allow_r)
      else $error("Non-SMM host read not blocked");
   a_range_bounds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_valid |=> dec_in_range_r == ($past(acc_addr[31:20]) >= $past(cfg.bottom_bound) &&
                                       $past(acc_addr[31:20]) <= $past(cfg.top_bound)))
      else $error("Range hit disagrees with bounds");
endmodule

// ===== rtl/srg_range_guard.sv
// Top of the protected memory range guard: control register plus access checker.
// Assumes a single-cycle message-port register access and one access request at a time.
// Overview of operation
// - Bits 31:20 hold the top bound, reset zero, compared with address bits 31:20.
// - Bits 15:4 hold the bottom bound, reset zero, compared with address bits 31:20.
// - Bit 2, reset one, lets the host write the range outside management mode.
// - Bit 1, reset one, lets the host read the range outside management mode.
// - Bit 18, reset one and lockable, lets other agents write the range.
// - Bit 17, reset one and lockable, lets other agents read the range.
// - Bit 0 is a write-once freeze that ignores all later writes until reset.
// - The low twenty address bits count as zero for the bottom bound and as all ones for the top bound.
// - Spare bits 19, 16 and 3 read zero and ignore writes.
module srg_range_guard
   import srg_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata_r,
   output logic             reg_ack_r,
   // Access request
   input  wire logic        acc_valid,
   input  wire logic [31:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic        acc_host,
   input  wire logic        acc_smm,
   // Decision
   output logic             dec_valid_r,
   output logic             dec_allow_r,
   output logic             dec_in_range_r,
   // Status
   output logic             config_frozen
);
   logic [11:0] range_top_bound_r;
   logic [11:0] range_bottom_bound_r;
   logic        other_agent_write_open_r;
   logic        other_agent_read_open_r;
   logic        outside_mode_write_open_r;
   logic        outside_mode_read_open_r;
   logic        config_freeze_bit_r;
   logic        wr_hit;
   logic [31:0] ctrl_value;

   // Index decode shared by the write path, the read path and the checks
   function automatic logic ctrl_sel(input logic [7:0] addr);
      return addr == SRG_CTRL_OFFSET;
   endfunction

   srg_cfg_if cfg_bus ();

   // Write accepted only at our offset and while unfrozen
   assign wr_hit = reg_wr && ctrl_sel(reg_addr) && !config_freeze_bit_r;

   // Assemble the register image; spare bits are constant zero
   always_comb begin
      ctrl_value                             = 32'h00000000;
      ctrl_value[SRG_TOP_MSB:SRG_TOP_LSB]    = range_top_bound_r;
      ctrl_value[SRG_OA_WR_BIT]              = other_agent_write_open_r;
      ctrl_value[SRG_OA_RD_BIT]              = other_agent_read_open_r;
      ctrl_value[SRG_BOT_MSB:SRG_BOT_LSB]    = range_bottom_bound_r;
      ctrl_value[SRG_OM_WR_BIT]              = outside_mode_write_open_r;
      ctrl_value[SRG_OM_RD_BIT]              = outside_mode_read_open_r;
      ctrl_value[SRG_FREEZE_BIT]             = config_freeze_bit_r;
   end

   // Bound fields
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         range_top_bound_r    <= SRG_TOP_RST;
         range_bottom_bound_r <= SRG_BOT_RST;
      end else if (wr_hit) begin
         range_top_bound_r    <= reg_wdata[SRG_TOP_MSB:SRG_TOP_LSB];
         range_bottom_bound_r <= reg_wdata[SRG_BOT_MSB:SRG_BOT_LSB];
      end
   end

   // Open bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         other_agent_write_open_r  <= SRG_OPEN_RST;
         other_agent_read_open_r   <= SRG_OPEN_RST;
         outside_mode_write_open_r <= SRG_OPEN_RST;
         outside_mode_read_open_r  <= SRG_OPEN_RST;
      end else if (wr_hit) begin
         other_agent_write_open_r  <= reg_wdata[SRG_OA_WR_BIT];
         other_agent_read_open_r   <= reg_wdata[SRG_OA_RD_BIT];
         outside_mode_write_open_r <= reg_wdata[SRG_OM_WR_BIT];
         outside_mode_read_open_r  <= reg_wdata[SRG_OM_RD_BIT];
      end
   end

   // Freeze bit: once set only reset clears it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_freeze_bit_r <= SRG_FREEZE_RST;
      end else if (wr_hit && reg_wdata[SRG_FREEZE_BIT]) begin
         config_freeze_bit_r <= 1'b1;
      end
   end

   // Register read and acknowledge; unmapped offsets read zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= 32'h00000000;
         reg_ack_r   <= 1'b0;
      end else begin
         reg_ack_r <= reg_wr || reg_rd;
         if (reg_rd && ctrl_sel(reg_addr)) begin
            reg_rdata_r <= ctrl_value;
         end else if (reg_rd) begin
            reg_rdata_r <= 32'h00000000;
         end
      end
   end

   assign config_frozen                    = config_freeze_bit_r;
   assign cfg_bus.top_bound                = range_top_bound_r;
   assign cfg_bus.bottom_bound             = range_bottom_bound_r;
   assign cfg_bus.outside_mode_write_open  = outside_mode_write_open_r;
   assign cfg_bus.outside_mode_read_open   = outside_mode_read_open_r;
   assign cfg_bus.other_agent_write_open   = other_agent_write_open_r;
   assign cfg_bus.other_agent_read_open    = other_agent_read_open_r;

   // Access decision, one cycle after the request
   srg_access_check u_check (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .cfg            (cfg_bus.dst),
      .acc_valid      (acc_valid),
      .acc_addr       (acc_addr),
      .acc_write      (acc_write),
      .acc_host       (acc_host),
      .acc_smm        (acc_smm),
      .dec_valid_r    (dec_valid_r),
      .dec_allow_r    (dec_allow_r),
      .dec_in_range_r (dec_in_range_r)
   );

   // Register-port request shapes; all but s_ctrl_write are used by the checks below
   sequence s_ctrl_write;
      reg_wr && ctrl_sel(reg_addr);
   endsequence

   sequence s_ctrl_read;
      reg_rd && ctrl_sel(reg_addr);
   endsequence

   sequence s_other_read;
      reg_rd && !ctrl_sel(reg_addr);
   endsequence

   sequence s_locked_write;
      reg_wr && ctrl_sel(reg_addr) && config_freeze_bit_r;
   endsequence

   sequence s_freeze_write;
      wr_hit && reg_wdata[SRG_FREEZE_BIT];
   endsequence

   // Freeze bit: nothing in the image moves while it is set
   a_frozen_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      config_freeze_bit_r |=> $stable(ctrl_value))
      else $error("Register changed while frozen");

   // Freeze bit: only reset clears it
   a_freeze_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      config_freeze_bit_r |=> config_freeze_bit_r)
      else $error("Freeze bit cleared without reset");

   // Freeze bit: set by the very write that carries it
   a_freeze_takes: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_freeze_write |=> config_freeze_bit_r)
      else $error("Freeze write did not set the bit");

   // Late writes are dropped but still acknowledged, so a caller never hangs
   a_locked_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_locked_write |=> reg_ack_r && ctrl_value == $past(ctrl_value))
      else $error("Frozen register accepted a write");

   // Unfrozen write lands in every writable field
   a_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_hit |=> ctrl_value == (($past(reg_wdata) & SRG_WR_MASK) | {31'h0, $past(config_freeze_bit_r)}))
      else $error("Unfrozen write did not land");

   // Spare bits never read back as one
   a_spare_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ctrl_read |=> reg_rdata_r[19] == 1'b0 && reg_rdata_r[16] == 1'b0 && reg_rdata_r[3] == 1'b0)
      else $error("Spare bit read nonzero");

   // Read returns the image as it stood when the strobe was taken
   a_read_image: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ctrl_read |=> reg_rdata_r == $past(ctrl_value))
      else $error("Read data differs from register");

   // Nothing else lives on this port, so other indexes read zero
   a_other_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_other_read |=> reg_rdata_r == 32'h00000000)
      else $error("Unmapped index read nonzero");

   // Read data stands until the next read
   a_rdata_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata_r))
      else $error("Read data moved without a read");

   // Every strobe is acknowledged one cycle later, and only then
   a_ack_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr || reg_rd) |=> reg_ack_r)
      else $error("Strobe not acknowledged");
   a_ack_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(reg_wr || reg_rd) |=> !reg_ack_r)
      else $error("Acknowledge without strobe");

   // First edge out of reset sees the reset image in every field
   a_reset_image: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> range_top_bound_r == SRG_TOP_RST && range_bottom_bound_r == SRG_BOT_RST
                       && other_agent_write_open_r == SRG_OPEN_RST && other_agent_read_open_r == SRG_OPEN_RST
                       && outside_mode_write_open_r == SRG_OPEN_RST && outside_mode_read_open_r == SRG_OPEN_RST
                       && config_freeze_bit_r == SRG_FREEZE_RST)
      else $error("Register not at reset image");
endmodule

// ===== verification/srg_agent_model.sv
// Model of the host processor and the other bus agents that ask the guard for memory accesses.
// Assumes one caller at a time; each call makes one request held for one clock.
module srg_agent_model (
   // Clock
   input  wire logic ref_clk,
   // Access request
   output logic        acc_valid,
   output logic [31:0] acc_addr,
   output logic        acc_write,
   output logic        acc_host,
   output logic        acc_smm
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle at time zero
   initial begin
      acc_valid = 1'b0;
      acc_addr  = 32'h0;
      acc_write = 1'b0;
      acc_host  = 1'b0;
      acc_smm   = 1'b0;
   end
   // Released address and write lines flip so a stale address never passes for a held one
   task automatic issue(input logic [31:0] addr, input logic wr, input logic host, input logic smm);
      @(posedge ref_clk);
      acc_valid <= 1'b1;
      acc_addr  <= addr;
      acc_write <= wr;
      acc_host  <= host;
      acc_smm   <= smm;
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      acc_addr  <= ~addr;
      acc_write <= ~wr;
   endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the protected range guard: register port and access decisions.
// Assumes the guard answers one cycle after each register strobe and each access request.
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tb_top
   import srg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata_r, acc_addr;
   logic        reg_ack_r, acc_valid, acc_write, acc_host, acc_smm;
   logic        dec_valid_r, dec_allow_r, dec_in_range_r, config_frozen;
   int          mismatches = 0;
   int          num_checks = 0;
   logic [31:0] shadow     = 32'h00060006; // Register value after reset
   logic [32:0] reg_q[$];                  // Bit 32 marks a read
   logic [1:0]  acc_q[$];
   logic [32:0] rnote;
   logic [1:0]  anote;
   srg_range_guard srg_range_guard_i (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r,
      .reg_ack_r, .acc_valid, .acc_addr, .acc_write, .acc_host, .acc_smm, .dec_valid_r, .dec_allow_r,
      .dec_in_range_r, .config_frozen);
   srg_agent_model srg_agent_model_i (.ref_clk, .acc_valid, .acc_addr, .acc_write, .acc_host, .acc_smm);
   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;
   // Expected decision {allow, hit}, built from the field layout alone
   function automatic logic [1:0] exp_dec(logic [31:0] c, logic [31:0] a, logic w, logic h, logic s);
      logic hit;
      hit = (a[31:20] >= c[15:4]) && (a[31:20] <= c[31:20]);
      return {!hit || (h && s) || (h ? (w ? c[2] : c[1]) : (w ? c[18] : c[17])), hit};
   endfunction
   // One strobe per call; the shadow copy follows the write-once freeze
   task automatic reg_op(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge ref_clk);
      reg_wr    <= wr;
      reg_rd    <= !wr;
      reg_addr  <= addr;
      reg_wdata <= data;
      if (wr && addr == SRG_CTRL_OFFSET && !shadow[0])
         shadow = data & SRG_WR_MASK;
      reg_q.push_back({!wr, (addr == SRG_CTRL_OFFSET) ? shadow : 32'h0});
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask
   task automatic access(input logic [31:0] a, input logic w, input logic h, input logic s);
      acc_q.push_back(exp_dec(shadow, a, w, h, s));
      srg_agent_model_i.issue(a, w, h, s);
   endtask
   // Lets answers drain, then makes sure every note was consumed
   task automatic settle(input string name);
      repeat (3) @(posedge ref_clk);
      `CHK(reg_q.size() + acc_q.size(), 0)
      $display("test %0s done", name);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watcher: answers are settled by the falling edge
   always @(negedge ref_clk) begin
      if (reg_ack_r === 1'b1) begin
         if (reg_q.size() == 0)
            `CHK(reg_ack_r, 1'b0)
         else begin
            rnote = reg_q.pop_front();
            if (rnote[32])
               `CHK(reg_rdata_r, rnote[31:0])
         end
      end
      if (dec_valid_r === 1'b1) begin
         anote = acc_q.size() ? acc_q.pop_front() : 2'bxx;
         `CHK({dec_allow_r, dec_in_range_r}, anote)
      end
   end
   // Watchdog: the tests need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      stop_test();
   end
   initial begin
      logic [31:0] cfg;
      logic [11:0] bot;
      void'($urandom(97));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      reg_op(1'b0, SRG_CTRL_OFFSET, 32'h0);
      reg_op(1'b1, SRG_CTRL_OFFSET, 32'hFFFFFFFE);
      reg_op(1'b0, SRG_CTRL_OFFSET, 32'h0);
      reg_op(1'b1, 8'h05, 32'h12345678);
      reg_op(1'b0, 8'h05, 32'h0);
      reg_op(1'b0, SRG_CTRL_OFFSET, 32'h0);
      settle("register");
      // First pass is the firmware setup with all four open bits set; later passes open bits at random
      for (int k = 0; k < 6; k++) begin
         bot = 12'h3FD + 12'($urandom_range(1));
         cfg = {12'h3FE, 1'b0, 2'($urandom), 1'b0, bot, 1'b0, 2'($urandom), 1'b0};
         if (k == 0) begin
            bot = 12'h3FD;
            cfg = 32'h3FE63FD6;
         end
         reg_op(1'b1, SRG_CTRL_OFFSET, cfg);
         for (int j = 0; j < 8; j++) begin
            access({bot - 12'h1, 20'hFFFFF}, j[0], j[1], j[2]);
            access({bot, 20'h00000}, j[0], j[1], j[2]);
            access({12'h3FE, 20'hFFFFF}, j[0], j[1], j[2]);
            access({12'h3FF, 20'h00000}, j[0], j[1], j[2]);
         end
      end
      settle("decisions");
      reg_op(1'b1, SRG_CTRL_OFFSET, 32'h3FE03FE1);
      reg_op(1'b1, SRG_CTRL_OFFSET, 32'h00060006);
      reg_op(1'b0, SRG_CTRL_OFFSET, 32'h0);
      for (int j = 0; j < 8; j++)
         access({12'h3FE, 20'h00000}, j[0], j[1], j[2]);
      settle("freeze");
      `CHK(config_frozen, 1'b1)
      @(posedge ref_clk);
      rst_n <= 1'b0;
      shadow = 32'h00060006;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      reg_op(1'b0, SRG_CTRL_OFFSET, 32'h0);
      settle("second reset");
      `CHK(config_frozen, 1'b0)
      stop_test();
   end
endmodule
